// >>> src/cop_ctrl.sv
`timescale 1ns/10ps
module cop_ctrl #(
  parameter int unsigned POWERUP_TIMER_CYCLES = cop_pkg::POWERUP_TIMER_CYC,
  parameter int unsigned OST_CYCLES = cop_pkg::OST_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [cop_pkg::CFG_W-1:0] cfg_word,
  input wire logic wake_pulse,
  input wire logic osc_in_level,
  input wire logic osc_in_edge,
  input wire logic rx_buf_full,
  input wire logic [cop_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic chip_reset_hold,
  output logic watchdog_enable,
  output logic calib_space_protect,
  output logic program_space_protect,
  output logic high_speed_crystal_mode,
  output logic osc_out_level,
  output logic pushbutton_irq_req,
  output logic serial_clk_hold_low,
  output logic serial_port_pin_select,
  output logic smbus_thresholds,
  output logic port_c_ground_select,
  output logic port_d_ground_select
);
  import cop_pkg::*;

  cop_state_t state_r, state_nxt;
  logic [CFG_W-1:0] cfg_r, cfg_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [7:0] pc_r, pc_nxt;
  logic [1:0] div_r, div_nxt;
  logic osc_prev_r, osc_prev_nxt;
  logic ack_r, ack_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic hold_r, hold_nxt;
  logic [10:0] outs_r, outs_nxt;
  logic in_mode;

  assign in_mode = cfg_r[CFG_OSC_BIT];

  // Start-up sequencer: capture strap, then timers
  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    osc_prev_nxt = osc_in_level;
    case (state_r)
      COP_CAPTURE: begin
        cfg_nxt = cfg_word;
        cnt_nxt = '0;
        if (!cfg_word[CFG_POWERUP_TIMER_N_BIT]) begin
          state_nxt = COP_POWERUP_TIMER;
        end else if (!cfg_word[CFG_OSC_BIT]) begin
          state_nxt = COP_OST;
        end else begin
          state_nxt = COP_INWAIT;
        end
      end
      COP_POWERUP_TIMER: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(POWERUP_TIMER_CYCLES - 1)) begin
          cnt_nxt = '0;
          state_nxt = in_mode ? COP_INWAIT : COP_OST;
        end
      end
      COP_OST: begin
        // Counts rising edges on the first oscillator pin
        if (osc_in_level && !osc_prev_r) begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CNT_W'(OST_CYCLES - 1)) begin
            cnt_nxt = '0;
            state_nxt = COP_RUN;
          end
        end
      end
      COP_INWAIT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == CNT_W'(INOSC_CYC - 1)) begin
          cnt_nxt = '0;
          state_nxt = COP_RUN;
        end
      end
      COP_RUN: begin
        if (wake_pulse && in_mode) begin
          cnt_nxt = '0;
          state_nxt = COP_INWAIT;
        end
      end
      default: state_nxt = COP_CAPTURE;
    endcase
    hold_nxt = (state_nxt != COP_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= COP_CAPTURE;
      cfg_r <= CFG_ERASED;
      cnt_r <= '0;
      hold_r <= 1'b1;
      osc_prev_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      cnt_r <= cnt_nxt;
      hold_r <= hold_nxt;
      osc_prev_r <= osc_prev_nxt;
    end
  end

  // Register slave: one wait cycle, then acknowledge
  always_comb begin
    pc_nxt = pc_r;
    ack_nxt = 1'b0;
    rd_nxt = rd_r;
    if ((avs_read || avs_write) && !ack_r) begin
      ack_nxt = 1'b1;
      rd_nxt = '0;
      if (avs_read) begin
        case (avs_address)
          PIN_CTRL_OFS: begin
            rd_nxt[7:1] = pc_r[7:1];
            rd_nxt[PC_OSC_IN] = in_mode & osc_in_level;
          end
          CFG_RD_OFS: rd_nxt[CFG_W-1:0] = cfg_r;
          STAT_OFS: rd_nxt[2:0] = state_r;
          default: rd_nxt = '0;
        endcase
      end
    end
    // Write lands at the edge where the master sees waitrequest low
    if (avs_write && ack_r && avs_address == PIN_CTRL_OFS) begin
      pc_nxt = (pc_r & ~PIN_CTRL_WMASK) | (avs_writedata[7:0] & PIN_CTRL_WMASK);
    end
    wait_nxt = !ack_nxt;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= PIN_CTRL_RST;
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rd_r <= '0;
    end else if (clk_en) begin
      pc_r <= pc_nxt;
      ack_r <= ack_nxt;
      wait_r <= wait_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rd_r;

  // Pin and decode outputs, all registered
  always_comb begin
    div_nxt = div_r + 1'b1;
    outs_nxt[0] = cfg_r[CFG_WDT_BIT];
    outs_nxt[1] = !cfg_r[CFG_CAL_PROT_BIT];
    outs_nxt[2] = !(cfg_r[CFG_PROG_HI_BIT] && cfg_r[CFG_PROG_LO_BIT]);
    outs_nxt[3] = !in_mode;
    // Internal clock divided by four, or the latch; held low in crystal mode
    if (!in_mode) begin
      outs_nxt[4] = 1'b0;
    end else if (pc_r[PC_CLKOUT]) begin
      outs_nxt[4] = div_r[1];
    end else begin
      outs_nxt[4] = pc_r[PC_OSC_OUT];
    end
    outs_nxt[5] = in_mode && osc_in_edge && !hold_r;
    outs_nxt[6] = pc_r[PC_STRETCH] && rx_buf_full;
    outs_nxt[7] = pc_r[PC_PORTSEL];
    outs_nxt[8] = pc_r[PC_SMBUS];
    outs_nxt[9] = pc_r[PC_GND_C];
    outs_nxt[10] = pc_r[PC_GND_D];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      outs_r <= '0;
    end else if (clk_en) begin
      div_r <= div_nxt;
      outs_r <= outs_nxt;
    end
  end

  assign chip_reset_hold = hold_r;
  assign watchdog_enable = outs_r[0];
  assign calib_space_protect = outs_r[1];
  assign program_space_protect = outs_r[2];
  assign high_speed_crystal_mode = outs_r[3];
  assign osc_out_level = outs_r[4];
  assign pushbutton_irq_req = outs_r[5];
  assign serial_clk_hold_low = outs_r[6];
  assign serial_port_pin_select = outs_r[7];
  assign smbus_thresholds = outs_r[8];
  assign port_c_ground_select = outs_r[9];
  assign port_d_ground_select = outs_r[10];

  a_hold_until_run: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state_r != COP_RUN) |-> chip_reset_hold)
    else $error("reset hold released before run");

  a_stretch_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && pc_r[PC_STRETCH] && rx_buf_full |=> serial_clk_hold_low)
    else $error("serial clock not stretched");

  sequence s_inwait_entry;
    $rose(state_r == COP_INWAIT);
  endsequence

  sequence s_enabled_8;
    clk_en [*8];
  endsequence

  sequence s_write_pin;
    clk_en && avs_write && ack_r && avs_address == PIN_CTRL_OFS;
  endsequence

  a_inwait_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_inwait_entry ##0 s_enabled_8 |=> (state_r == COP_RUN))
    else $error("internal wait length wrong");

  a_bit0_readonly: assert property (@(posedge core_clk) disable iff (!rst_n)
    pc_r[PC_OSC_IN] == 1'b0)
    else $error("input bit stored");

  a_hs_no_pinout: assert property (@(posedge core_clk) disable iff (!rst_n)
    !in_mode && $past(!in_mode) |-> !osc_out_level && !pushbutton_irq_req)
    else $error("pin function active in crystal mode");

  a_wdt_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == COP_RUN |-> watchdog_enable == cfg_r[CFG_WDT_BIT])
    else $error("watchdog decode wrong");

  a_portsel_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_write_pin |=> pc_r[PC_PORTSEL] == $past(avs_writedata[PC_PORTSEL]))
    else $error("port select not written");

  a_answer_time: assert property (@(posedge core_clk) disable iff (!rst_n)
    (avs_read || avs_write) && !ack_r && clk_en |=> !avs_waitrequest)
    else $error("bus answer late");

  a_wait_after_ack: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ack_r |=> avs_waitrequest)
    else $error("waitrequest low too long");

  a_pin_read: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && avs_read && !ack_r && avs_address == PIN_CTRL_OFS
    |=> avs_readdata[PC_OSC_IN] == $past(in_mode && osc_in_level))
    else $error("input pin read wrong");

  a_irq_pulse: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && in_mode && osc_in_edge && !chip_reset_hold |=> pushbutton_irq_req)
    else $error("pin interrupt missing");

  a_gnd_d_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> port_d_ground_select == $past(pc_r[PC_GND_D]))
    else $error("port d ground select wrong");

  a_gnd_c_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> port_c_ground_select == $past(pc_r[PC_GND_C]))
    else $error("port c ground select wrong");

  a_smbus_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en |=> smbus_thresholds == $past(pc_r[PC_SMBUS]))
    else $error("threshold select wrong");

  a_powerup_timer_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && state_r == COP_POWERUP_TIMER && cnt_r == CNT_W'(POWERUP_TIMER_CYCLES - 1)
    |=> state_r != COP_POWERUP_TIMER)
    else $error("power-up timer overran");

  a_ost_only_hs: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == COP_OST |-> !in_mode)
    else $error("start-up timer in internal mode");

  a_cal_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == COP_RUN |-> calib_space_protect == !cfg_r[CFG_CAL_PROT_BIT])
    else $error("calibration protect decode wrong");

  a_prog_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == COP_RUN |-> program_space_protect == !(cfg_r[CFG_PROG_HI_BIT] && cfg_r[CFG_PROG_LO_BIT]))
    else $error("program protect decode wrong");

  a_cfg_static: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == COP_RUN |=> $stable(cfg_r))
    else $error("configuration changed in run");
endmodule // cop_ctrl

// >>> src/cop_pkg.sv
package cop_pkg;
  localparam int unsigned CFG_W = 14;
  localparam logic [13:0] CFG_ERASED = 14'h3fff;
  localparam logic [15:0] CFG_WORD_ADDR = 16'h2007;
  localparam logic [15:0] CFG_SPACE_TOP = 16'h3fff;
  localparam int unsigned CFG_CAL_PROT_BIT = 7;
  localparam int unsigned CFG_PROG_HI_BIT = 5;
  localparam int unsigned CFG_PROG_LO_BIT = 4;
  localparam int unsigned CFG_POWERUP_TIMER_N_BIT = 3;
  localparam int unsigned CFG_WDT_BIT = 2;
  localparam int unsigned CFG_OSC_BIT = 0;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] PIN_CTRL_OFS = 8'h9e;
  localparam logic [7:0] CFG_RD_OFS = 8'ha0;
  localparam logic [7:0] STAT_OFS = 8'ha4;
  localparam logic [7:0] PIN_CTRL_RST = 8'h00;
  localparam logic [7:0] PIN_CTRL_WMASK = 8'hfe;
  localparam int unsigned PC_OSC_IN = 0;
  localparam int unsigned PC_OSC_OUT = 1;
  localparam int unsigned PC_CLKOUT = 2;
  localparam int unsigned PC_SMBUS = 3;
  localparam int unsigned PC_PORTSEL = 4;
  localparam int unsigned PC_GND_C = 5;
  localparam int unsigned PC_GND_D = 6;
  localparam int unsigned PC_STRETCH = 7;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned POWERUP_TIMER_MS = 72;
  localparam int unsigned POWERUP_TIMER_CYC = POWERUP_TIMER_MS * (CLK_HZ / 1000);
  localparam int unsigned OST_CYC = 1024;
  localparam int unsigned INOSC_CYC = 8;
  localparam int unsigned NOMINAL_IN_HZ = 4000000;
  localparam int unsigned CNT_W = 21;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  typedef enum logic [2:0] {COP_CAPTURE, COP_POWERUP_TIMER, COP_OST, COP_INWAIT, COP_RUN}
    cop_state_t;
endpackage

// >>> testbench/cop_osc_src.sv
`timescale 1ns/10ps
module cop_osc_src (
  input wire logic core_clk,
  input wire logic run,
  input wire logic btn,
  output logic level
);
  logic [1:0] cnt_r = 2'h0;
  logic osc_r = 1'b0;
  // Crystal mode: a clock source on the first pin, eight core cycles a period
  always @(posedge core_clk) begin
    cnt_r <= cnt_r + 2'h1;
    if (cnt_r == 2'h3) osc_r <= ~osc_r;
  end
  // Internal mode: pushbutton input, pulled up when released
  assign level = run ? osc_r : btn;
endmodule // cop_osc_src

// >>> testbench/tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  import cop_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, osc_in_edge = 1'b0, rx_buf_full = 1'b0, btn = 1'b1;
  logic [13:0] cfg_word = CFG_ERASED;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, chip_reset_hold, osc_in_level;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic watchdog_enable, calib_space_protect, program_space_protect, high_speed_crystal_mode;
  logic osc_out_level, pushbutton_irq_req, serial_clk_hold_low, serial_port_pin_select;
  logic smbus_thresholds, port_c_ground_select, port_d_ground_select;
  logic clk_en = 1'b1, wake_pulse = 1'b0;
  int n_errors = 0, checks_done = 0, n;
  cop_ctrl #(.POWERUP_TIMER_CYCLES(20), .OST_CYCLES(4)) DUT (.core_clk, .rst_n, .clk_en,
    .cfg_word, .wake_pulse, .osc_in_level, .osc_in_edge, .rx_buf_full, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .chip_reset_hold,
    .watchdog_enable, .calib_space_protect, .program_space_protect, .high_speed_crystal_mode,
    .osc_out_level, .pushbutton_irq_req, .serial_clk_hold_low, .serial_port_pin_select,
    .smbus_thresholds, .port_c_ground_select, .port_d_ground_select);
  cop_osc_src osc (.core_clk, .run(high_speed_crystal_mode), .btn, .level(osc_in_level));
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One Avalon transfer; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic done;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    if (w) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    k = 0;
    done = 1'b0;
    // Answer is read while it stands, the request is dropped after that edge
    do begin
      @(negedge core_clk);
      done = (avs_waitrequest === 1'b0);
      rd = avs_readdata;
      @(posedge core_clk);
      k++;
    end while (!done && k < 20);
    `CHK("bus answer", 1'b1, done)
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Reset with a given configuration, then count cycles until start-up ends
  task automatic boot(input logic [13:0] cfg);
    @(posedge core_clk);
    rst_n <= 1'b0;
    cfg_word <= cfg;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      @(negedge core_clk);
    end while (chip_reset_hold !== 1'b0 && n < 300);
  endtask
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
  initial begin
    boot(CFG_ERASED);
    `CHK("no powerup_timer", 1 + INOSC_CYC, n)
    `CHK("wdt", 1'b1, watchdog_enable)
    `CHK("cal prot", 1'b0, calib_space_protect)
    `CHK("prog prot", 1'b0, program_space_protect)
    `CHK("hs", 1'b0, high_speed_crystal_mode)
    bus(1'b0, CFG_RD_OFS, 32'h0);
    `CHK("cfg", 32'h3fff, rd)
    bus(1'b0, PIN_CTRL_OFS, 32'h0);
    `CHK("pin rst", 32'h01, rd)
    btn <= 1'b0;
    bus(1'b1, PIN_CTRL_OFS, 32'hff);
    bus(1'b0, PIN_CTRL_OFS, 32'h0);
    `CHK("pin rd", 32'hfe, rd)
    `CHK("psel", 1'b1, serial_port_pin_select)
    `CHK("smb", 1'b1, smbus_thresholds)
    `CHK("gnd c", 1'b1, port_c_ground_select)
    `CHK("gnd d", 1'b1, port_d_ground_select)
    rx_buf_full <= 1'b1;
    n = 0;
    repeat (8) begin
      @(negedge core_clk);
      n += int'(osc_out_level);
    end
    `CHK("stretch", 1'b1, serial_clk_hold_low)
    `CHK("clk div4", 1'b1, n == 4)
    bus(1'b1, PIN_CTRL_OFS, 32'h02);
    repeat (2) @(posedge core_clk);
    `CHK("out pin", 1'b1, osc_out_level)
    `CHK("no stretch", 1'b0, serial_clk_hold_low)
    bus(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    @(posedge core_clk);
    osc_in_edge <= 1'b1;
    @(posedge core_clk);
    osc_in_edge <= 1'b0;
    @(negedge core_clk);
    `CHK("irq", 1'b1, pushbutton_irq_req)
    @(posedge core_clk);
    clk_en <= 1'b0;
    wake_pulse <= 1'b1;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    wake_pulse <= 1'b0;
    @(negedge core_clk);
    `CHK("frozen wake", 1'b0, chip_reset_hold)
    @(posedge core_clk);
    wake_pulse <= 1'b1;
    @(posedge core_clk);
    wake_pulse <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      @(negedge core_clk);
    end while (chip_reset_hold !== 1'b0 && n < 300);
    `CHK("wake wait", INOSC_CYC, n)
    boot(14'h3f62);
    `CHK("powerup_timer+ost", 1'b1, n > 45 && n < 54)
    `CHK("hs", 1'b1, high_speed_crystal_mode)
    `CHK("wdt off", 1'b0, watchdog_enable)
    `CHK("cal prot", 1'b1, calib_space_protect)
    `CHK("prog prot", 1'b1, program_space_protect)
    bus(1'b1, PIN_CTRL_OFS, 32'h06);
    repeat (2) @(posedge core_clk);
    `CHK("hs out pin", 1'b0, osc_out_level)
    end_sim();
  end
endmodule // tb
